// file: sim/selcall_dtmf_tone_codec_tb.sv
// Self-checking bench: host and tone codec joined over the register bus
`timescale 1ns/1ps
module selcall_dtmf_tone_codec_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] u_addr = 8'h00;
    logic [15:0] u_wdata = 16'h0000;
    logic u_wr = 1'b0;
    logic u_rd = 1'b0;
    logic dig_v = 1'b0;
    logic dig_rs = 1'b0;
    logic [3:0] dig = 4'h0;
    logic ib_v = 1'b0;
    logic [11:0] ib_f = 12'h000;
    logic dt_v = 1'b0;
    logic [3:0] dt_c = 4'h0;
    logic [15:0] h_rdata, h_report;
    logic h_sent, h_rep_v, h_rxv, txv, act;
    logic [3:0] h_code, att;
    logic [11:0] fa, fb;
    logic [7:0] lvl;
    int failures = 0;
    int n_checks = 0;
    // Expected tone frequencies, code 0 at the right
    logic [15:0][11:0] sel_hz = {12'h41F, 12'h83E, 12'h3DF, 12'h8C7, 12'h3A2, 12'h960,
        12'h744, 12'h6D3, 12'h668, 12'h604, 12'h5A6, 12'h54E, 12'h4FB, 12'h4AD, 12'h464, 12'h7BD};
    logic [15:0][11:0] lo_hz = {12'h354, 12'h302, 12'h2B9, 12'h3AD, 12'h3AD, 12'h3AD,
        12'h354, 12'h354, 12'h354, 12'h302, 12'h302, 12'h302, 12'h2B9, 12'h2B9, 12'h2B9, 12'h3AD};
    logic [15:0][11:0] hi_hz = {12'h661, 12'h661, 12'h661, 12'h5C5, 12'h4B9, 12'h538,
        12'h5C5, 12'h538, 12'h4B9, 12'h5C5, 12'h538, 12'h4B9, 12'h5C5, 12'h538, 12'h4B9, 12'h661};

    always #5 clk = ~clk;

    // ----------------------------------------
    // Ends and checker
    // ----------------------------------------
    tone_bus_if bus ();
    tone_codec i_tone_codec (.i_clk(clk), .i_rst(rst), .i_ce(ce), .bus(bus),
        .i_inband_valid(ib_v), .i_inband_freq(ib_f), .i_dtmf_valid(dt_v), .i_dtmf_code(dt_c),
        .o_tx_voice_en(txv), .o_tone_active(act), .o_tone_freq_a(fa), .o_tone_freq_b(fb),
        .o_tone_b_atten_db(att), .o_tone_level(lvl));
    tone_host i_tone_host (.i_clk(clk), .i_rst(rst), .i_ce(ce), .bus(bus), .i_addr(u_addr),
        .i_wdata(u_wdata), .i_wr(u_wr), .i_rd(u_rd), .o_rdata(h_rdata), .i_digit_valid(dig_v),
        .i_digit(dig), .i_digit_restart(dig_rs), .o_digit_sent(h_sent), .o_sent_code(h_code),
        .o_report_valid(h_rep_v), .o_report(h_report), .o_rx_voice_en(h_rxv));
    tone_codec_props i_tone_codec_props (.i_clk(clk), .i_rst(rst), .addr(bus.addr),
        .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .irq(bus.irq));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Extra edge at the end lets generator outputs settle
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        u_addr <= a;
        u_wdata <= d;
        u_wr <= 1'b1;
        @(posedge clk);
        u_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        u_addr <= a;
        u_rd <= 1'b1;
        @(posedge clk);
        u_rd <= 1'b0;
        #1 d = h_rdata;
    endtask

    task automatic wait_for(ref logic flag);
        int k;
        k = 0;
        #1;
        while (flag !== 1'b1 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (flag !== 1'b1) begin
            failures++;
            print_verdict();
        end
    endtask

    task automatic send_digit(input logic [3:0] d, input logic [3:0] exp);
        @(posedge clk);
        dig <= d;
        dig_v <= 1'b1;
        @(posedge clk);
        dig_v <= 1'b0;
        wait_for(h_sent);
        check("sent code", {12'h000, exp}, {12'h000, h_code});
        @(posedge clk);
    endtask

    task automatic rx_step(input logic iv, input logic [11:0] f, input logic dv,
        input logic [3:0] dc, input logic [15:0] exp, input logic rxv);
        @(posedge clk);
        ib_v <= iv;
        ib_f <= f;
        dt_v <= dv;
        dt_c <= dc;
        wait_for(h_rep_v);
        check("report", exp, h_report);
        check("rx voice", {15'h0000, rxv}, {15'h0000, h_rxv});
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        logic [15:0] v;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_reg(8'hC3, v);
        check("tx reset", 16'h0000, v);
        rd_reg(8'hCC, v);
        check("report reset", 16'h0000, v);
        rd_reg(8'h00, v);
        check("unmapped", 16'h0000, v);
        rd_reg(8'hCD, v);
        check("audio read", 16'h0000, v);
        check("level reset", 16'h00FF, {8'h00, lvl});
        for (int c = 0; c < 16; c++) begin
            wr_reg(8'hC3, {1'b0, c[3:0], 11'h400});
            check("sel hz", {4'h0, sel_hz[c]}, {4'h0, fa});
            check("sel b", 16'h0000, {4'h0, fb});
            check("tx voice", 16'h0000, {15'h0000, txv});
            check("active", 16'h0001, {15'h0000, act});
        end
        for (int c = 0; c < 16; c++) begin
            wr_reg(8'hC3, {12'h020, c[3:0]});
            check("dtmf a", {4'h0, hi_hz[c]}, {4'h0, fa});
            check("dtmf b", {4'h0, lo_hz[c]}, {4'h0, fb});
            check("no twist", 16'h0000, {12'h000, att});
            wr_reg(8'hC3, {12'h022, c[3:0]});
            check("twist", 16'h0002, {12'h000, att});
            wr_reg(8'hC3, {12'h021, c[3:0]});
            check("single a", {4'h0, (c >= 8) ? hi_hz[c] : lo_hz[c]}, {4'h0, fa});
            check("single b", 16'h0000, {4'h0, fb});
        end
        wr_reg(8'hC3, 16'h2A3B);
        rd_reg(8'hC3, v);
        check("tx readback", 16'h2A3B, v);
        wr_reg(8'hC3, 16'h0000);
        check("voice back", 16'h0001, {15'h0000, txv});
        check("idle", 16'h0000, {15'h0000, act});
        wr_reg(8'hCD, 16'hB05A);
        check("level", 16'h005A, {8'h00, lvl});
        // Wrong command prefix must leave the level alone
        wr_reg(8'hCD, 16'hA033);
        check("level kept", 16'h005A, {8'h00, lvl});
        // Clock enable low must drop the write
        ce <= 1'b0;
        wr_reg(8'hCD, 16'hB011);
        check("level frozen", 16'h005A, {8'h00, lvl});
        ce <= 1'b1;
        send_digit(4'h3, 4'h3);
        send_digit(4'h3, 4'hE);
        send_digit(4'h3, 4'h3);
        @(posedge clk);
        dig_rs <= 1'b1;
        @(posedge clk);
        dig_rs <= 1'b0;
        send_digit(4'h3, 4'h3);
        wr_reg(8'hC3, 16'h0000);
        // Same frequency in two slots: lowest slot must win
        wr_reg(8'hC8, 16'h3123);
        wr_reg(8'hC8, 16'h8123);
        wr_reg(8'hC3, 16'h1C00);
        check("loaded hz", 16'h0123, {4'h0, fa});
        wr_reg(8'hC3, 16'h0000);
        rx_step(1'b1, 12'h123, 1'b0, 4'h0, 16'h9800, 1'b0);
        rx_step(1'b1, 12'h749, 1'b0, 4'h0, 16'hC800, 1'b0);
        rx_step(1'b1, 12'h83E, 1'b0, 4'h0, 16'hF000, 1'b0);
        rx_step(1'b0, 12'h000, 1'b0, 4'h0, 16'h0000, 1'b1);
        rd_reg(8'hCC, v);
        check("report clear", 16'h0000, v);
        rx_step(1'b0, 12'h000, 1'b1, 4'h5, 16'h2C00, 1'b0);
        rx_step(1'b0, 12'h000, 1'b0, 4'h5, 16'h0000, 1'b1);
        print_verdict();
    end
endmodule

// file: sim/tone_codec_props.sv
// Concurrent checks on the register bus between host and tone codec
`timescale 1ns/1ps
module tone_codec_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic irq
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // ----------------------------------------
    // Read data framing
    // ----------------------------------------
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    a_unmapped_zero: assert property (rd && !(addr inside {8'hC3, 8'hC6, 8'hCC})
        |=> rdata == 16'h0000)
        else $error("write-only or unmapped read not zero");
    // Mask drops bit 15 and bits 8-6, which the tone register stores but the generator does not use
    a_tx_readback: assert property (wr && addr == 8'hC3 ##1 !wr [*2] ##1 rd && addr == 8'hC3
        |=> (rdata & 16'h7E3F) == ($past(wdata, 4) & 16'h7E3F))
        else $error("tone select readback differs from write");
    // ----------------------------------------
    // Status and interrupt
    // ----------------------------------------
    a_status_fields: assert property (rd && addr == 8'hC6
        |=> rdata[15:14] == 2'h0 && rdata[11:0] == 12'h000)
        else $error("status has bits outside event fields");
    a_status_irq: assert property (rd && addr == 8'hC6
        |=> (rdata[13] | rdata[12]) == $past(irq))
        else $error("interrupt level disagrees with status");
    a_irq_hold: assert property (irq && !(rd && addr == 8'hC6) |=> irq)
        else $error("interrupt dropped without status read");
    a_irq_drop: assert property ($fell(irq) |-> $past(rd) && $past(addr) == 8'hC6)
        else $error("interrupt fell without preceding status read");
    // ----------------------------------------
    // Tone report shape
    // ----------------------------------------
    a_report_fields: assert property (rd && addr == 8'hCC
        |=> rdata[9:0] == 10'h000 && !(rdata[15] && rdata[10]))
        else $error("report carries stray bits or both flags");
    a_report_empty: assert property (rd && addr == 8'hCC
        |=> rdata[15] || rdata[10] || rdata == 16'h0000)
        else $error("report holds a code without a flag");
endmodule

// file: src/tone_bus_if.sv
// Register bus and interrupt between host and tone codec
`timescale 1ns/1ps
interface tone_bus_if;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic irq;
    modport device (input addr, input wdata, input wr, input rd, output rdata, output irq);
    modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

// file: src/tone_codec.sv
// Signalling tone codec: register file, tone generator control, receive reporting
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Function
// - Tone generation disables transmit voice path
// - Selcall code b14-11, DTMF code b3-0
// - Tone level from B-prefixed audio command
// - Twist drops low DTMF tone 2 dB
// - Single-tone outputs only the designated component
// - Status b13 on inband on/off/change
// - Descending table scan, lowest matching entry reported
// - Selcall detect sets b15, code b14-11
// - Report cleared when received tone ends
// - Default table holds standard sixteen frequencies
// - Host sends code 14 for repeats
// - Repeat tone reported as ordinary code
// - Status b12 on DTMF start/stop
// - DTMF present sets b10, code b14-11
// - DTMF code to key and frequencies
// - Loaded table used for generation and detection
// - Host mutes receive voice around tones
// - Host reads report after tone interrupt
// - Host avoids both detectors at once (host does not enforce this; codec reports inband first when both are valid)
module tone_codec #(
    parameter logic [11:0] MATCH_TOL = 12'h00A
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    tone_bus_if.device bus,
    input wire logic i_inband_valid,
    input wire logic [11:0] i_inband_freq,
    input wire logic i_dtmf_valid,
    input wire logic [3:0] i_dtmf_code,
    output logic o_tx_voice_en,
    output logic o_tone_active,
    output logic [11:0] o_tone_freq_a,
    output logic [11:0] o_tone_freq_b,
    output logic [3:0] o_tone_b_atten_db,
    output logic [7:0] o_tone_level
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] tx_tone;
        logic [7:0] level;
        logic [15:0][11:0] table_hz;
        logic [1:0] evt;
        logic [15:0] report;
        logic in_prev;
        logic [3:0] in_code_prev;
        logic dtmf_prev;
        logic [15:0] rdata;
        logic irq;
        logic voice_en;
        logic active;
        logic [11:0] freq_a;
        logic [11:0] freq_b;
        logic [3:0] atten;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic [15:0] hit;

    localparam int RPT_SEL_FLAG_I = tone_codec_pkg::RPT_SEL_FLAG;
    localparam int RPT_DTMF_FLAG_I = tone_codec_pkg::RPT_DTMF_FLAG;
    localparam int RPT_CODE_LSB_I = tone_codec_pkg::RPT_CODE_LSB;
    localparam int ST_IN_I = tone_codec_pkg::ST_INBAND_EVT;
    localparam int ST_DT_I = tone_codec_pkg::ST_DTMF_EVT;
    localparam int AUD_CMD_I = tone_codec_pkg::AUDIO_CMD_LSB;
    localparam int PROG_IDX_I = tone_codec_pkg::PROG_IDX_LSB;
    localparam int TX_SEL_LSB_I = tone_codec_pkg::TX_SEL_LSB;
    localparam int TX_DTMF_LSB_I = tone_codec_pkg::TX_DTMF_LSB;
    localparam int TX_SEL_EN_I = tone_codec_pkg::TX_SEL_EN;
    localparam int TX_DTMF_EN_I = tone_codec_pkg::TX_DTMF_EN;
    localparam int TX_SINGLE_I = tone_codec_pkg::TX_SINGLE;
    localparam int TX_TWIST_I = tone_codec_pkg::TX_TWIST;

    // ------------------------------------------------------------
    // Table comparison
    // ------------------------------------------------------------
    // Tolerance window keeps detector jitter from flipping codes
    for (genvar i = 0; i < 16; i++) begin : g_match
        assign hit[i] = (i_inband_freq >= s_q.table_hz[i]) ?
            ((i_inband_freq - s_q.table_hz[i]) <= MATCH_TOL) :
            ((s_q.table_hz[i] - i_inband_freq) <= MATCH_TOL);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] in_code;
        logic in_now;
        logic in_evt;
        logic dtmf_evt;
        logic [3:0] sel;
        logic [3:0] dc;
        logic [11:0] lo;
        logic [11:0] hi;
        in_code = 4'h0;
        in_now = 1'b0;
        in_evt = 1'b0;
        dtmf_evt = 1'b0;
        sel = 4'h0;
        dc = 4'h0;
        lo = 12'h000;
        hi = 12'h000;
        s_d = s_q;
        // Highest index first so the lowest matching entry wins
        for (int k = 15; k >= 0; k--) begin
            if (hit[k]) begin
                in_code = 4'(k);
            end
        end
        in_now = i_inband_valid && (|hit);
        // Repeat code gets no special handling on receive
        in_evt = (in_now != s_q.in_prev) || (in_now && in_code != s_q.in_code_prev);
        dtmf_evt = i_dtmf_valid != s_q.dtmf_prev;
        s_d.in_prev = in_now;
        s_d.in_code_prev = in_now ? in_code : 4'h0;
        s_d.dtmf_prev = i_dtmf_valid;

        // Inband has priority when both detectors report
        if (in_now) begin
            s_d.report = 16'h0000;
            s_d.report[RPT_SEL_FLAG_I] = 1'b1;
            s_d.report[RPT_CODE_LSB_I +: 4] = in_code;
        end else if (i_dtmf_valid) begin
            s_d.report = 16'h0000;
            s_d.report[RPT_DTMF_FLAG_I] = 1'b1;
            s_d.report[RPT_CODE_LSB_I +: 4] = i_dtmf_code;
        end else begin
            s_d.report = 16'h0000;
        end

        // Read answers, one cycle after the strobe
        s_d.rdata = 16'h0000;
        if (bus.rd) begin
            if (bus.addr == tone_codec_pkg::ADDR_TX_TONE) begin
                s_d.rdata = s_q.tx_tone;
            end else if (bus.addr == tone_codec_pkg::ADDR_STATUS) begin
                s_d.rdata[ST_IN_I] = s_q.evt[1];
                s_d.rdata[ST_DT_I] = s_q.evt[0];
            end else if (bus.addr == tone_codec_pkg::ADDR_REPORT) begin
                s_d.rdata = s_q.report;
            end
        end

        // Reading status services it; a new event in that cycle still lands
        if (bus.rd && bus.addr == tone_codec_pkg::ADDR_STATUS) begin
            s_d.evt = 2'b00;
        end
        if (in_evt) begin
            s_d.evt[1] = 1'b1;
        end
        if (dtmf_evt) begin
            s_d.evt[0] = 1'b1;
        end
        s_d.irq = |s_d.evt;

        // Writes
        if (bus.wr) begin
            if (bus.addr == tone_codec_pkg::ADDR_TX_TONE) begin
                s_d.tx_tone = bus.wdata;
            end else if (bus.addr == tone_codec_pkg::ADDR_AUDIO) begin
                if (bus.wdata[AUD_CMD_I +: 4] == tone_codec_pkg::AUDIO_CMD_LEVEL) begin
                    s_d.level = bus.wdata[7:0];
                end
            end else if (bus.addr == tone_codec_pkg::ADDR_TABLE_PROG) begin
                s_d.table_hz[bus.wdata[PROG_IDX_I +: 4]] = bus.wdata[11:0];
            end
        end

        // Tone generator, driven from the stored select register
        sel = s_q.tx_tone[TX_SEL_LSB_I +: 4];
        dc = s_q.tx_tone[TX_DTMF_LSB_I +: 4];
        lo = tone_codec_pkg::DTMF_LOW[tone_codec_pkg::DTMF_ROW[dc]];
        hi = tone_codec_pkg::DTMF_HIGH[tone_codec_pkg::DTMF_COL[dc]];
        s_d.active = s_q.tx_tone[TX_SEL_EN_I] | s_q.tx_tone[TX_DTMF_EN_I];
        s_d.voice_en = ~s_d.active;
        s_d.freq_a = 12'h000;
        s_d.freq_b = 12'h000;
        s_d.atten = 4'h0;
        if (s_q.tx_tone[TX_SEL_EN_I]) begin
            s_d.freq_a = s_q.table_hz[sel];
        end else if (s_q.tx_tone[TX_DTMF_EN_I]) begin
            if (s_q.tx_tone[TX_SINGLE_I]) begin
                s_d.freq_a = tone_codec_pkg::DTMF_SINGLE_HIGH[dc] ? hi : lo;
            end else begin
                s_d.freq_a = hi;
                s_d.freq_b = lo;
                if (s_q.tx_tone[TX_TWIST_I]) begin
                    s_d.atten = tone_codec_pkg::TWIST_DB;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.tx_tone <= tone_codec_pkg::TX_TONE_RESET;
            s_q.level <= tone_codec_pkg::LEVEL_RESET;
            s_q.table_hz <= tone_codec_pkg::DEFAULT_TABLE;
            s_q.voice_en <= 1'b1;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign bus.rdata = s_q.rdata;
    assign bus.irq = s_q.irq;
    assign o_tx_voice_en = s_q.voice_en;
    assign o_tone_active = s_q.active;
    assign o_tone_freq_a = s_q.freq_a;
    assign o_tone_freq_b = s_q.freq_b;
    assign o_tone_b_atten_db = s_q.atten;
    assign o_tone_level = s_q.level;
endmodule

// file: src/tone_codec_pkg.sv
// Shared constants for the signalling tone codec and its host
package tone_codec_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TX_TONE = 8'hC3;
    localparam logic [7:0] ADDR_STATUS = 8'hC6;
    localparam logic [7:0] ADDR_TABLE_PROG = 8'hC8;
    localparam logic [7:0] ADDR_REPORT = 8'hCC;
    localparam logic [7:0] ADDR_AUDIO = 8'hCD;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TX_SEL_LSB = 11;
    localparam int TX_DTMF_LSB = 0;
    localparam int TX_SEL_EN = 10;
    localparam int TX_DTMF_EN = 9;
    localparam int TX_TWIST = 5;
    localparam int TX_SINGLE = 4;
    localparam int ST_INBAND_EVT = 13;
    localparam int ST_DTMF_EVT = 12;
    localparam int RPT_SEL_FLAG = 15;
    localparam int RPT_CODE_LSB = 11;
    localparam int RPT_DTMF_FLAG = 10;
    localparam int AUDIO_CMD_LSB = 12;
    localparam logic [3:0] AUDIO_CMD_LEVEL = 4'hB;
    localparam int PROG_IDX_LSB = 12;
    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [15:0] TX_TONE_RESET = 16'h0000;
    localparam logic [7:0] LEVEL_RESET = 8'hFF;
    localparam logic [3:0] TWIST_DB = 4'h2;
    localparam logic [3:0] REPEAT_CODE = 4'hE;
    localparam logic [15:0][11:0] DEFAULT_TABLE = {
        12'h41F, 12'h83E, 12'h3DF, 12'h8C7, 12'h3A2, 12'h960, 12'h744, 12'h6D3,
        12'h668, 12'h604, 12'h5A6, 12'h54E, 12'h4FB, 12'h4AD, 12'h464, 12'h7BD};
    localparam logic [3:0][11:0] DTMF_LOW = {12'h3AD, 12'h354, 12'h302, 12'h2B9};
    localparam logic [3:0][11:0] DTMF_HIGH = {12'h661, 12'h5C5, 12'h538, 12'h4B9};
    // Row and column per code, code 0 at the right
    localparam logic [15:0][1:0] DTMF_ROW = {
        2'h2, 2'h1, 2'h0, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2,
        2'h2, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h3};
    localparam logic [15:0][1:0] DTMF_COL = {
        2'h3, 2'h3, 2'h3, 2'h2, 2'h0, 2'h1, 2'h2, 2'h1,
        2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h3};
    // Set where the single tone is the high one
    localparam logic [15:0] DTMF_SINGLE_HIGH = 16'hFF00;
endpackage

// file: src/tone_host.sv
// Host end: command pass-through, repeat insertion, interrupt service
`timescale 1ns/1ps
module tone_host (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    tone_bus_if.host bus,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic i_digit_valid,
    input wire logic [3:0] i_digit,
    input wire logic i_digit_restart,
    output logic o_digit_sent,
    output logic [3:0] o_sent_code,
    output logic o_report_valid,
    output logic [15:0] o_report,
    output logic o_rx_voice_en
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SVC_IDLE, SVC_STATUS, SVC_REPORT, SVC_CAPTURE} svc_e;

    typedef struct packed {
        svc_e svc;
        logic last_valid;
        logic [3:0] last_code;
        logic sent;
        logic [3:0] sent_code;
        logic rpt_valid;
        logic [15:0] report;
        logic rx_voice_en;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic user;
    logic digit_go;
    logic [3:0] code;
    logic [15:0] tone_word;

    // ------------------------------------------------------------
    // Bus arbitration: user, then digit, then interrupt service
    // ------------------------------------------------------------
    always_comb begin
        user = i_wr | i_rd;
        digit_go = i_digit_valid & ~user;
        // Device never inserts repeats itself
        code = (s_q.last_valid && i_digit == s_q.last_code) ?
            tone_codec_pkg::REPEAT_CODE : i_digit;
        tone_word = 16'h0000;
        tone_word[tone_codec_pkg::TX_SEL_LSB +: 4] = code;
        tone_word[tone_codec_pkg::TX_SEL_EN] = 1'b1;
        bus.addr = 8'h00;
        bus.wdata = 16'h0000;
        bus.wr = 1'b0;
        bus.rd = 1'b0;
        if (user) begin
            bus.addr = i_addr;
            bus.wdata = i_wdata;
            bus.wr = i_wr;
            bus.rd = i_rd;
        end else if (digit_go) begin
            bus.addr = tone_codec_pkg::ADDR_TX_TONE;
            bus.wdata = tone_word;
            bus.wr = 1'b1;
        end else if (s_q.svc == SVC_STATUS) begin
            bus.addr = tone_codec_pkg::ADDR_STATUS;
            bus.rd = 1'b1;
        end else if (s_q.svc == SVC_REPORT) begin
            bus.addr = tone_codec_pkg::ADDR_REPORT;
            bus.rd = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sent = 1'b0;
        s_d.rpt_valid = 1'b0;
        if (i_digit_restart) begin
            s_d.last_valid = 1'b0;
        end else if (digit_go) begin
            s_d.last_valid = 1'b1;
            s_d.last_code = code;
            s_d.sent = 1'b1;
            s_d.sent_code = code;
        end
        case (s_q.svc)
            SVC_IDLE: begin
                if (bus.irq) begin
                    s_d.svc = SVC_STATUS;
                end
            end
            SVC_STATUS: begin
                if (!user && !digit_go) begin
                    s_d.svc = SVC_REPORT;
                end
            end
            SVC_REPORT: begin
                if (!user && !digit_go) begin
                    s_d.svc = SVC_CAPTURE;
                end
            end
            SVC_CAPTURE: begin
                s_d.svc = SVC_IDLE;
                s_d.report = bus.rdata;
                s_d.rpt_valid = 1'b1;
                // Mute while any tone is reported
                s_d.rx_voice_en = (bus.rdata == 16'h0000);
            end
            default: begin
                s_d.svc = SVC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.svc <= SVC_IDLE;
            s_q.rx_voice_en <= 1'b1;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // Read data comes from the device's own answer register
    assign o_rdata = bus.rdata;
    assign o_digit_sent = s_q.sent;
    assign o_sent_code = s_q.sent_code;
    assign o_report_valid = s_q.rpt_valid;
    assign o_report = s_q.report;
    assign o_rx_voice_en = s_q.rx_voice_en;
endmodule
